// File: pkg/fco_pkg.sv
// fco_pkg: shared constants and types for the flash clock and security options block
// assumes: one 100 MHz bus clock, apb register access, nonvolatile bytes stable after reset
//
// Overview of operation
// [RULE_01] loaded flag read-only; first divider write sets it
// [RULE_02] prescale/divisor readable always, writable once
// [RULE_03] program/erase disabled until loaded flag set
// [RULE_04] prescale bit selects bus clock or bus/8
// [RULE_05] divider divides selected input by divisor+1
// [RULE_06] software keeps timing clock 150-200 kHz
// [RULE_07] timing pulse is one timing clock period
// [RULE_08] options byte copied at reset, fixed afterwards
// [RULE_09] backdoor disabled means key never unlocks
// [RULE_10] key writes only from secure firmware, never debug
// [RULE_11] eight matching bytes in order unlock until reset
// [RULE_12] redirect-disable bit one turns redirection off
// [RULE_13] security code unsecured only for 1:0
// [RULE_14] secure memory hidden from unsecured and debug sources
// [RULE_15] key match or blank check sets code 1:0
// [RULE_16] key-write-enable routes key-range writes to compare
// [RULE_17] blocked writes ignored, blocked reads return zero
// [RULE_18] set enable, write bytes ascending, clear to compare
// [RULE_19] command before divider write sets access error
// [RULE_20] later divider writes change nothing
package fco_pkg;
	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_DIV = 8'h00; // timing_divider_reg
	localparam logic [7:0] OFF_OPT = 8'h04; // working_options_reg
	localparam logic [7:0] OFF_CFG = 8'h08; // config_reg
	localparam logic [7:0] OFF_STAT = 8'h0C; // status register
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int DIVISOR_LOADED_BIT = 7;
	localparam int PRESCALE_BIT = 6;
	localparam int BACKDOOR_ENABLE_BIT = 7;
	localparam int NORED_BIT = 6;
	localparam int KEY_WRITE_ENABLE_BIT = 5;
	localparam int STAT_SECURE_BIT = 0;
	localparam int STAT_RANGE_BIT = 1;
	localparam int STAT_PE_EN_BIT = 2;
	localparam int STAT_ACCERR_BIT = 4;
	// ---------------------------------------------------------------
	// reset values and encodings
	// ---------------------------------------------------------------
	localparam logic [6:0] DIV_RST = 7'h00;
	localparam logic [7:0] OPT_RST = 8'hFF; // erased state: secure until copied
	localparam logic [1:0] SEC_UNSECURED = 2'h2;
	localparam logic [15:0] KEY_BASE = 16'hFFB0;
	localparam logic [3:0] KEY_LEN = 4'h8;
	localparam logic [2:0] PRESCALE_LAST = 3'h7; // divide by eight
	// ---------------------------------------------------------------
	// timing: allowed timing clock band and derived bus-cycle periods
	// ---------------------------------------------------------------
	localparam int PCLK_HZ = 100000000;
	localparam int FCLK_MAX_HZ = 200000;
	localparam int FCLK_MIN_HZ = 150000;
	localparam logic [9:0] PERIOD_MIN_CYC = 10'((PCLK_HZ + FCLK_MAX_HZ - 1) / FCLK_MAX_HZ);
	localparam logic [9:0] PERIOD_MAX_CYC = 10'(PCLK_HZ / FCLK_MIN_HZ);
	// key comparison states, gray coded
	typedef enum logic [1:0] {
		FCO_KEY_IDLE = 2'h0,
		FCO_KEY_COLLECT = 2'h1,
		FCO_KEY_CHECK = 2'h3
	} fco_key_state_t;
endpackage

// File: rtl/fco_timing_div.sv
// fco_timing_div: derives the program/erase timing pulse from the bus clock
// assumes: settings held stable once run is high
`timescale 1ns/1ps
module fco_timing_div (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// settings
	input wire logic run,
	input wire logic prescale,
	input wire logic [5:0] divisor,
	// one-cycle pulse per timing clock period
	output logic tick_ff
);
	import fco_pkg::*;
	logic [2:0] pre_cnt_ff; // prescale counter
	logic [5:0] div_cnt_ff; // divisor counter
	logic [2:0] nxt_pre_cnt;
	logic [5:0] nxt_div_cnt;
	logic nxt_tick;
	logic pre_done; // one prescaled input edge
	// ---------------------------------------------------------------
	// counting
	// ---------------------------------------------------------------
	always_comb begin
		pre_done = !prescale || (pre_cnt_ff == PRESCALE_LAST); // [RULE_04]
		nxt_pre_cnt = 3'h0;
		nxt_div_cnt = div_cnt_ff;
		nxt_tick = 1'b0;
		if (run) begin
			if (prescale && !pre_done) begin
				nxt_pre_cnt = pre_cnt_ff + 3'h1;
			end
			if (pre_done) begin
				// divide by divisor plus one
				if (div_cnt_ff == divisor) begin // [RULE_05]
					nxt_div_cnt = 6'h00;
					nxt_tick = 1'b1; // [RULE_07]
				end else begin
					nxt_div_cnt = div_cnt_ff + 6'h01;
				end
			end
		end else begin
			nxt_div_cnt = 6'h00;
		end
	end
	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_cnt_ff <= 3'h0;
			div_cnt_ff <= 6'h00;
			tick_ff <= 1'b0;
		end else begin
			pre_cnt_ff <= nxt_pre_cnt;
			div_cnt_ff <= nxt_div_cnt;
			tick_ff <= nxt_tick;
		end
	end
endmodule // fco_timing_div

// File: rtl/fco_key_cmp.sv
// fco_key_cmp: collects backdoor key bytes and compares them on disable
// assumes: key_wr already filtered to secure firmware sources
`timescale 1ns/1ps
module fco_key_cmp (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic key_write_enable,
	input wire logic backdoor_enable,
	// key byte writes
	input wire logic key_wr,
	input wire logic [2:0] key_idx,
	input wire logic [7:0] key_byte,
	input wire logic [63:0] nv_backdoor_key,
	// one-cycle unlock pulse
	output logic unlock_ff
);
	import fco_pkg::*;
	fco_key_state_t state_ff, nxt_state;
	logic [3:0] cnt_ff, nxt_cnt; // bytes written
	logic ok_ff, nxt_ok; // all bytes so far matched in order
	logic nxt_unlock;
	// ---------------------------------------------------------------
	// sequence
	// ---------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_ok = ok_ff;
		nxt_unlock = 1'b0;
		case (state_ff)
			FCO_KEY_IDLE: begin
				// enable raised: start fresh
				if (key_write_enable) begin // [RULE_18]
					nxt_state = FCO_KEY_COLLECT;
					nxt_cnt = 4'h0;
					nxt_ok = 1'b1;
				end
			end
			FCO_KEY_COLLECT: begin
				if (!key_write_enable) begin
					nxt_state = FCO_KEY_CHECK;
				end else if (key_wr) begin
					// ascending order and matching value, no extra bytes
					if (cnt_ff == KEY_LEN || key_idx != cnt_ff[2:0] ||
						key_byte != nv_backdoor_key[8 * key_idx +: 8]) begin // [RULE_11]
						nxt_ok = 1'b0;
					end
					if (cnt_ff != KEY_LEN) begin
						nxt_cnt = cnt_ff + 4'h1;
					end
				end
			end
			FCO_KEY_CHECK: begin
				// compare result only counts with backdoor enabled
				nxt_unlock = ok_ff && (cnt_ff == KEY_LEN) && backdoor_enable; // [RULE_09] [RULE_18]
				nxt_state = FCO_KEY_IDLE;
			end
			default: begin
				nxt_state = FCO_KEY_IDLE;
			end
		endcase
	end
	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= FCO_KEY_IDLE;
			cnt_ff <= 4'h0;
			ok_ff <= 1'b0;
			unlock_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			ok_ff <= nxt_ok;
			unlock_ff <= nxt_unlock;
		end
	end
endmodule // fco_key_cmp

// File: rtl/fco_flash_cfg.sv
// fco_flash_cfg: flash clock divider, options and security gate with apb registers
// assumes: nonvolatile bytes valid at reset release; memory port on the bus clock
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module fco_flash_cfg (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_ff,
	output logic pready_ff,
	output logic pslverr_ff,
	// nonvolatile contents
	input wire logic [7:0] nv_options_byte,
	input wire logic [63:0] nv_backdoor_key,
	// cpu or debug access to secure memory
	input wire logic mem_req,
	input wire logic mem_wr,
	input wire logic mem_is_flash,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_src_secure,
	input wire logic mem_src_debug,
	input wire logic [7:0] arr_rdata,
	output logic [7:0] mem_rdata_ff,
	output logic mem_blocked_ff,
	output logic mem_wr_ok_ff,
	// sequencer side
	input wire logic blank_check_ok,
	output logic cmd_start_ff,
	output logic timing_tick_ff,
	output logic prog_erase_en_ff,
	output logic secure_ff,
	output logic redirect_disable_ff
);
	import fco_pkg::*;
	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	logic [6:0] div_ff, nxt_div; // prescale and divisor
	logic divisor_loaded_ff, nxt_divisor_loaded; // divisor_loaded
	logic [7:0] opt_ff, nxt_opt; // working_options_reg
	logic opt_loaded_ff, nxt_opt_loaded; // options copy done
	logic key_write_enable_ff, nxt_key_write_enable; // key_write_enable
	logic acc_err_ff, nxt_acc_err; // access_error_flag
	logic nxt_pready, nxt_pslverr;
	logic [31:0] nxt_prdata;
	logic nxt_secure, nxt_pe_en, nxt_redirect;
	logic [7:0] nxt_mem_rdata;
	logic nxt_blocked, nxt_wr_ok, nxt_cmd;
	logic wr_div, wr_cfg, wr_stat; // register write strobes
	logic mapped; // address hits a register
	logic [9:0] period_cyc; // bus cycles per timing period
	logic range_ok; // period inside allowed band
	logic blocked; // current access refused
	logic key_range; // address in key window
	logic key_wr; // byte handed to comparator
	logic flash_wr; // write that starts a command
	logic key_unlock; // comparator match
	logic tick;
	// ---------------------------------------------------------------
	// apb decode
	// ---------------------------------------------------------------
	always_comb begin
		mapped = (paddr == OFF_DIV) || (paddr == OFF_OPT) || (paddr == OFF_CFG) || (paddr == OFF_STAT);
		// writes land at the access edge that completes the transfer
		wr_div = psel && penable && pready_ff && pwrite && (paddr == OFF_DIV);
		wr_cfg = psel && penable && pready_ff && pwrite && (paddr == OFF_CFG);
		wr_stat = psel && penable && pready_ff && pwrite && (paddr == OFF_STAT);
		// no wait state: ready in the first access cycle only
		nxt_pready = psel && !penable;
		nxt_pslverr = psel && !penable && !mapped;
		nxt_prdata = 32'h0000_0000;
		if (psel && !penable) begin
			case (paddr)
				OFF_DIV: nxt_prdata = {24'h00_0000, divisor_loaded_ff, div_ff}; // [RULE_02]
				OFF_OPT: nxt_prdata = {24'h00_0000, opt_ff[7:6], 4'h0, opt_ff[1:0]};
				OFF_CFG: nxt_prdata = {26'h000_0000, key_write_enable_ff, 5'h00};
				OFF_STAT: nxt_prdata = {27'h000_0000, acc_err_ff, 1'b0, prog_erase_en_ff, range_ok, secure_ff};
				default: nxt_prdata = 32'h0000_0000;
			endcase
		end
	end
	// apb registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			prdata_ff <= nxt_prdata;
		end
	end
	// ---------------------------------------------------------------
	// divider register and band check
	// ---------------------------------------------------------------
	always_comb begin
		nxt_div = div_ff;
		nxt_divisor_loaded = divisor_loaded_ff;
		// only the first write after reset is kept
		if (wr_div && !divisor_loaded_ff) begin // [RULE_20]
			nxt_div = pwdata[6:0]; // [RULE_02]
			nxt_divisor_loaded = 1'b1; // [RULE_01]
		end
		// bus cycles per timing period: (divisor + 1), times eight when prescaled
		// divisor plus one overflows six bits at 63, so that code is patched below
		period_cyc = div_ff[PRESCALE_BIT] ? {1'b0, 3'(div_ff[5:0] + 6'h01 == 6'h00), 6'(div_ff[5:0] + 6'h01)} << 3
			: {3'h0, 1'b0, 6'(div_ff[5:0] + 6'h01)};
		if (div_ff[5:0] == 6'h3F) begin
			period_cyc = div_ff[PRESCALE_BIT] ? 10'h200 : 10'h040;
		end
		// software is expected to stay in band; status reports it
		range_ok = (period_cyc >= PERIOD_MIN_CYC) && (period_cyc <= PERIOD_MAX_CYC); // [RULE_06]
	end
	// divider registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= DIV_RST;
			divisor_loaded_ff <= 1'b0;
		end else begin
			div_ff <= nxt_div;
			divisor_loaded_ff <= nxt_divisor_loaded;
		end
	end
	// timing pulse generator, held idle until the divider is set
	fco_timing_div u_div (
		.pclk(pclk),
		.presetn(presetn),
		.run(divisor_loaded_ff),
		.prescale(div_ff[PRESCALE_BIT]),
		.divisor(div_ff[5:0]),
		.tick_ff(tick)
	);
	// ---------------------------------------------------------------
	// options, configuration and error flag
	// ---------------------------------------------------------------
	always_comb begin
		nxt_opt = opt_ff;
		nxt_opt_loaded = 1'b1;
		// copy once after reset release; never written by software
		if (!opt_loaded_ff) begin
			nxt_opt = nv_options_byte; // [RULE_08]
		end else if (key_unlock || blank_check_ok) begin
			nxt_opt[1:0] = SEC_UNSECURED; // [RULE_15]
		end
		nxt_key_write_enable = wr_cfg ? pwdata[KEY_WRITE_ENABLE_BIT] : key_write_enable_ff;
		// write-one clears, a new error in the same cycle wins
		nxt_acc_err = acc_err_ff;
		if (wr_stat && pwdata[STAT_ACCERR_BIT]) begin
			nxt_acc_err = 1'b0;
		end
		if (mem_req && flash_wr && !divisor_loaded_ff) begin
			nxt_acc_err = 1'b1; // [RULE_19]
		end
		nxt_secure = (opt_ff[1:0] != SEC_UNSECURED); // [RULE_13]
		nxt_pe_en = divisor_loaded_ff; // [RULE_03]
		nxt_redirect = opt_ff[NORED_BIT]; // [RULE_12]
	end
	// option registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opt_ff <= OPT_RST;
			opt_loaded_ff <= 1'b0;
			key_write_enable_ff <= 1'b0;
			acc_err_ff <= 1'b0;
			secure_ff <= 1'b1;
			prog_erase_en_ff <= 1'b0;
			redirect_disable_ff <= 1'b1;
		end else begin
			opt_ff <= nxt_opt;
			opt_loaded_ff <= nxt_opt_loaded;
			key_write_enable_ff <= nxt_key_write_enable;
			acc_err_ff <= nxt_acc_err;
			secure_ff <= nxt_secure;
			prog_erase_en_ff <= nxt_pe_en;
			redirect_disable_ff <= nxt_redirect;
		end
	end
	// ---------------------------------------------------------------
	// memory access gate
	// ---------------------------------------------------------------
	always_comb begin
		// unsecured code and debug are shut out while secure
		blocked = mem_req && secure_ff && (!mem_src_secure || mem_src_debug); // [RULE_14]
		// eight aligned key locations share the upper address bits
		key_range = mem_is_flash && (mem_addr[15:3] == KEY_BASE[15:3]);
		// key writes with capture on never reach the command path, whatever the source
		key_wr = mem_req && mem_wr && key_range && key_write_enable_ff && mem_src_secure && !mem_src_debug; // [RULE_10] [RULE_16]
		flash_wr = mem_wr && mem_is_flash && !blocked && !(key_range && key_write_enable_ff); // [RULE_16]
		nxt_blocked = blocked;
		nxt_mem_rdata = (mem_req && !mem_wr && !blocked) ? arr_rdata : 8'h00; // [RULE_17]
		nxt_wr_ok = mem_req && mem_wr && !blocked && !(key_range && key_write_enable_ff) && !(mem_is_flash && !divisor_loaded_ff); // [RULE_17]
		nxt_cmd = mem_req && flash_wr && divisor_loaded_ff; // [RULE_03]
	end
	// access registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_blocked_ff <= 1'b0;
			mem_rdata_ff <= 8'h00;
			mem_wr_ok_ff <= 1'b0;
			cmd_start_ff <= 1'b0;
			timing_tick_ff <= 1'b0;
		end else begin
			mem_blocked_ff <= nxt_blocked;
			mem_rdata_ff <= nxt_mem_rdata;
			mem_wr_ok_ff <= nxt_wr_ok;
			cmd_start_ff <= nxt_cmd;
			timing_tick_ff <= tick; // [RULE_07]
		end
	end
	// backdoor key comparison
	fco_key_cmp u_key (
		.pclk(pclk),
		.presetn(presetn),
		.key_write_enable(key_write_enable_ff),
		.backdoor_enable(opt_ff[BACKDOOR_ENABLE_BIT]),
		.key_wr(key_wr),
		.key_idx(mem_addr[2:0]),
		.key_byte(mem_wdata),
		.nv_backdoor_key(nv_backdoor_key),
		.unlock_ff(key_unlock)
	);
	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	a_divisor_loaded_sticky: assert property (@(posedge pclk) disable iff (!presetn) divisor_loaded_ff |=> divisor_loaded_ff) // [RULE_01]
		else $error("loaded flag dropped");
	a_first_write_sets: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_div && !divisor_loaded_ff) |=> (divisor_loaded_ff && div_ff == $past(pwdata[6:0]))) // [RULE_02]
		else $error("first divider write not stored");
	a_div_write_once: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_div && divisor_loaded_ff) |=> $stable(div_ff)) // [RULE_20]
		else $error("divider changed after first write");
	a_cmd_needs_divisor_loaded: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_start_ff |-> $past(divisor_loaded_ff)) // [RULE_03]
		else $error("command started before divider set");
	a_early_cmd_error: assert property (@(posedge pclk) disable iff (!presetn)
		(mem_req && flash_wr && !divisor_loaded_ff) |=> (acc_err_ff && !cmd_start_ff)) // [RULE_19]
		else $error("early command not flagged");
	a_blocked_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
		mem_blocked_ff |-> (mem_rdata_ff == 8'h00 && !mem_wr_ok_ff && !cmd_start_ff)) // [RULE_17]
		else $error("blocked access leaked");
	a_secure_decode: assert property (@(posedge pclk) disable iff (!presetn)
		opt_loaded_ff |=> (secure_ff == ($past(opt_ff[1:0]) != 2'h2))) // [RULE_13]
		else $error("security decode wrong");
	a_unlock_backdoor_enable: assert property (@(posedge pclk) disable iff (!presetn)
		key_unlock |-> opt_ff[BACKDOOR_ENABLE_BIT]) // [RULE_09]
		else $error("unlock without backdoor enable");
	a_unlock_sets_code: assert property (@(posedge pclk) disable iff (!presetn)
		(opt_loaded_ff && (key_unlock || blank_check_ok)) |=> ##1 !secure_ff) // [RULE_15]
		else $error("unlock did not clear security");
	a_debug_no_key: assert property (@(posedge pclk) disable iff (!presetn)
		mem_src_debug |-> !key_wr) // [RULE_10]
		else $error("debug key write accepted");
	a_opt_frozen: assert property (@(posedge pclk) disable iff (!presetn)
		(opt_loaded_ff && !key_unlock && !blank_check_ok) |=> $stable(opt_ff)) // [RULE_08]
		else $error("options changed without reset");
	a_redirect_follows: assert property (@(posedge pclk) disable iff (!presetn)
		opt_loaded_ff ##1 opt_loaded_ff |-> redirect_disable_ff == $past(opt_ff[NORED_BIT])) // [RULE_12]
		else $error("redirect output wrong");
	c_div_loaded: cover property (@(posedge pclk) disable iff (!presetn) wr_div && !divisor_loaded_ff);
	c_key_unlock: cover property (@(posedge pclk) disable iff (!presetn) key_unlock);
	c_blank_unlock: cover property (@(posedge pclk) disable iff (!presetn) blank_check_ok && secure_ff);
	a_tick_after_load: assert property (@(posedge pclk) disable iff (!presetn)
		timing_tick_ff |-> prog_erase_en_ff) // [RULE_07]
		else $error("timing pulse before divider set");
	a_key_no_cmd: assert property (@(posedge pclk) disable iff (!presetn)
		(mem_req && mem_wr && key_range && key_write_enable_ff) |=> !cmd_start_ff) // [RULE_16]
		else $error("key write started a command");
	c_blocked: cover property (@(posedge pclk) disable iff (!presetn) mem_blocked_ff);
	// divider set inside the allowed timing band
	c_in_band: cover property (@(posedge pclk) disable iff (!presetn) divisor_loaded_ff && range_ok);
endmodule // fco_flash_cfg

// File: tb/tb_top.sv
// tb_top: self-checking bench for the flash clock and security options block
// assumes: apb slave at fco_pkg offsets, memory port answers one cycle after a request
`timescale 1ns/1ps
module tb_top;
	import fco_pkg::*;
	// ---------------------------------------------------------------
	// signals and counters
	// ---------------------------------------------------------------
	logic pclk, presetn, psel, penable, pwrite, mem_req, mem_wr, mem_is_flash;
	logic mem_src_secure, mem_src_debug, blank_check_ok, pready_ff, pslverr_ff;
	logic mem_blocked_ff, mem_wr_ok_ff, cmd_start_ff, timing_tick_ff;
	logic prog_erase_en_ff, secure_ff, redirect_disable_ff;
	logic [7:0] paddr, nv_options_byte, mem_wdata, arr_rdata, mem_rdata_ff;
	logic [15:0] mem_addr;
	logic [31:0] pwdata, prdata_ff, rdat;
	logic [63:0] nv_backdoor_key;
	logic err;
	int n_mismatch = 0;
	int n_compared = 0;
	// stored key, arbitrary pattern
	localparam logic [63:0] KEY = 64'h0123_4567_89AB_CDEF;
	// ---------------------------------------------------------------
	// design and clock
	// ---------------------------------------------------------------
	fco_flash_cfg uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
		.nv_options_byte(nv_options_byte), .nv_backdoor_key(nv_backdoor_key), .mem_req(mem_req),
		.mem_wr(mem_wr), .mem_is_flash(mem_is_flash), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_src_secure(mem_src_secure), .mem_src_debug(mem_src_debug), .arr_rdata(arr_rdata),
		.mem_rdata_ff(mem_rdata_ff), .mem_blocked_ff(mem_blocked_ff), .mem_wr_ok_ff(mem_wr_ok_ff),
		.blank_check_ok(blank_check_ok), .cmd_start_ff(cmd_start_ff), .timing_tick_ff(timing_tick_ff),
		.prog_erase_en_ff(prog_erase_en_ff), .secure_ff(secure_ff), .redirect_disable_ff(redirect_disable_ff));
	// 100 MHz bus clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// verdict and end of run
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// one apb transfer: setup, then access until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// wait for the slave; only the watchdog ends a hung transfer
		do begin
			@(posedge pclk);
		end while (pready_ff !== 1'b1);
		rdat = prdata_ff;
		err = pslverr_ff;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// register read with expected value
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask
	// one memory access, outputs looked at in the answer cycle
	task automatic mem(input logic w, input logic f, input logic [15:0] a, input logic [7:0] d,
		input logic s, input logic g);
		@(posedge pclk);
		{mem_req, mem_wr, mem_is_flash, mem_src_secure, mem_src_debug} <= {1'b1, w, f, s, g};
		mem_addr <= a;
		mem_wdata <= d;
		arr_rdata <= d;
		@(posedge pclk);
		mem_req <= 1'b0;
		#1;
	endtask
	// key entry: enable capture, eight ascending bytes, then disable
	task automatic key(input logic [63:0] k, input logic g);
		apb(1'b1, OFF_CFG, 32'h20);
		for (int i = 0; i < 8; i++) begin
			mem(1'b1, 1'b1, KEY_BASE + 16'(i), k[8*i +: 8], !g, g);
			chk(cmd_start_ff, 1'b0);
		end
		apb(1'b1, OFF_CFG, 32'h00);
		repeat (5) @(posedge pclk);
	endtask
	// cycles between two timing ticks
	task automatic per(input int exp);
		int c;
		c = 0;
		while (timing_tick_ff !== 1'b1 && c < 2000) begin
			@(posedge pclk);
			c++;
		end
		c = 0;
		do begin
			@(posedge pclk);
			c++;
		end while (timing_tick_ff !== 1'b1 && c < 2000);
		chk(32'(c), 32'(exp));
	endtask
	// reset with a given options byte
	task automatic do_reset(input logic [7:0] nv);
		presetn <= 1'b0;
		nv_options_byte <= nv;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask
	// ---------------------------------------------------------------
	// watchdog: the whole run needs well under 10000 cycles
	// ---------------------------------------------------------------
	initial begin
		#100us;
		n_mismatch++;
		end_sim();
	end
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, mem_req, mem_wr, mem_is_flash} = '0;
		{mem_src_secure, mem_src_debug, blank_check_ok} = '0;
		{paddr, mem_wdata, arr_rdata, mem_addr, pwdata} = '0;
		nv_backdoor_key = KEY;
		nv_options_byte = 8'h83;
		do_reset(8'h83);
		// reset state and read-only options
		rd(OFF_OPT, 32'h83);
		rd(OFF_DIV, 32'h00);
		rd(OFF_STAT, 32'h01);
		chk(redirect_disable_ff, 1'b0);
		chk(prog_erase_en_ff, 1'b0);
		apb(1'b1, OFF_OPT, 32'h00);
		rd(OFF_OPT, 32'h83);
		rd(8'h10, 32'h00);
		chk(err, 1'b1);
		$display("test reset_state done");
		// blocked sources while secure, command before divider write
		mem(1'b0, 1'b1, 16'hE000, 8'h5A, 1'b0, 1'b1);
		chk({mem_rdata_ff, mem_blocked_ff}, {8'h00, 1'b1});
		mem(1'b1, 1'b0, 16'h0080, 8'h11, 1'b0, 1'b0);
		chk({mem_wr_ok_ff, mem_blocked_ff}, 2'b01);
		mem(1'b0, 1'b0, 16'h0080, 8'h3C, 1'b1, 1'b0);
		chk({mem_rdata_ff, mem_blocked_ff}, {8'h3C, 1'b0});
		mem(1'b1, 1'b1, 16'hE000, 8'h22, 1'b1, 1'b0);
		chk(cmd_start_ff, 1'b0);
		rd(OFF_STAT, 32'h11);
		apb(1'b1, OFF_STAT, 32'h10);
		rd(OFF_STAT, 32'h01);
		$display("test blocked_access done");
		// divider written once, prescale by eight and divisor 63
		apb(1'b1, OFF_DIV, 32'h7F);
		rd(OFF_DIV, 32'hFF);
		apb(1'b1, OFF_DIV, 32'h05);
		rd(OFF_DIV, 32'hFF);
		per(512);
		rd(OFF_STAT, 32'h07);
		chk(prog_erase_en_ff, 1'b1);
		mem(1'b1, 1'b1, 16'hE000, 8'h33, 1'b1, 1'b0);
		chk(cmd_start_ff, 1'b1);
		mem(1'b1, 1'b1, KEY_BASE, 8'h44, 1'b1, 1'b0);
		chk(cmd_start_ff, 1'b1);
		$display("test divider done");
		// backdoor key: wrong value, debug source, then a match
		key(~KEY, 1'b0);
		chk(secure_ff, 1'b1);
		key(KEY, 1'b1);
		chk(secure_ff, 1'b1);
		key(KEY, 1'b0);
		chk(secure_ff, 1'b0);
		rd(OFF_OPT, 32'h82);
		mem(1'b0, 1'b1, 16'hE000, 8'h77, 1'b0, 1'b1);
		chk({mem_rdata_ff, mem_blocked_ff}, {8'h77, 1'b0});
		$display("test backdoor done");
		// second reset: key disabled, redirection off, plain bus clock
		do_reset(8'h40);
		rd(OFF_OPT, 32'h40);
		chk({secure_ff, redirect_disable_ff}, 2'b11);
		rd(OFF_DIV, 32'h00);
		apb(1'b1, OFF_DIV, 32'h04);
		per(5);
		rd(OFF_STAT, 32'h05);
		key(KEY, 1'b0);
		chk(secure_ff, 1'b1);
		@(posedge pclk);
		blank_check_ok <= 1'b1;
		@(posedge pclk);
		blank_check_ok <= 1'b0;
		repeat (4) @(posedge pclk);
		chk(secure_ff, 1'b0);
		rd(OFF_OPT, 32'h42);
		$display("test second_reset done");
		end_sim();
	end
endmodule // tb_top
